// ==== rtl/bieg_top.sv ====
// buffer event status, interrupt enable register and summary interrupt flags
//
// Notes on behaviour
// - top byte enables buffer 3 events onto summary flag one
// - second byte enables buffer 2 events onto summary flag one
// - third byte enables buffer 1 events except empty onto summary flag zero
// - a cleared enable bit keeps its event away from the summary flag
// - bits 26, 18 and 10 ignore writes and read as zero
// - all enables reset to zero except buffer 2 empty, which resets to one
// - byte order: confirm, release, expired, wm1, wm0, reserved, full, empty
// - implemented enable bits are read-write and hold until rewritten or reset
// - event bits set by hardware, cleared when software reads them
`include "bieg_defines.svh"
`default_nettype none

module bieg_top (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // register port
  input  wire logic [11:0]           reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // buffer event strobes from the buffer manager
  input  wire bieg_pkg::bieg_buf_evt_t buf3_evt,
  input  wire bieg_pkg::bieg_buf_evt_t buf2_evt,
  input  wire bieg_pkg::bieg_buf_evt_t buf1_evt,
  // summary interrupt flags
  output logic                       summary_buffer_irq_one,
  output logic                       summary_buffer_irq_zero
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // place one buffer's event strobes into its register byte
  function automatic logic [7:0] bieg_evt_byte(input bieg_pkg::bieg_buf_evt_t evt);
    logic [7:0] b;
    b = 8'h00;
    b[`BIEG_FLD_CELL_CONFIRM] = evt.cell_confirm;
    b[`BIEG_FLD_TS_RELEASE]   = evt.ts_release;
    b[`BIEG_FLD_TS_EXPIRED]   = evt.ts_expired;
    b[`BIEG_FLD_WM_ONE]       = evt.wm_one;
    b[`BIEG_FLD_WM_ZERO]      = evt.wm_zero;
    b[`BIEG_FLD_RSVD]         = 1'b0;
    b[`BIEG_FLD_FULL]         = evt.full;
    b[`BIEG_FLD_EMPTY]        = evt.empty;
    return b;
  endfunction : bieg_evt_byte

  // pull one buffer's event fields back out of its register byte
  function automatic bieg_pkg::bieg_buf_evt_t bieg_byte_evt(input logic [7:0] b);
    bieg_pkg::bieg_buf_evt_t evt;
    evt              = '0;
    evt.cell_confirm = b[`BIEG_FLD_CELL_CONFIRM];
    evt.ts_release   = b[`BIEG_FLD_TS_RELEASE];
    evt.ts_expired   = b[`BIEG_FLD_TS_EXPIRED];
    evt.wm_one       = b[`BIEG_FLD_WM_ONE];
    evt.wm_zero      = b[`BIEG_FLD_WM_ZERO];
    evt.full         = b[`BIEG_FLD_FULL];
    evt.empty        = b[`BIEG_FLD_EMPTY];
    return evt;
  endfunction : bieg_byte_evt

  // true when a buffer has any event that is both pending and enabled
  function automatic logic bieg_buf_any(input bieg_pkg::bieg_buf_evt_t pend,
                                        input bieg_pkg::bieg_buf_evt_t en);
    return |(pend & en);
  endfunction : bieg_buf_any

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bieg_pkg::bieg_reg_req_t req;
  logic [31:0] buffer_irq_enable_reg_q;
  logic [31:0] buffer_irq_enable_reg_d;
  logic [31:0] buffer_event_status_reg_q;
  logic [31:0] buffer_event_status_reg_d;
  logic [31:0] reg_rdata_q;
  logic [31:0] reg_rdata_d;
  logic        irq_one_q;
  logic        irq_zero_q;
  bieg_pkg::bieg_buf_evt_t buf3_en;
  bieg_pkg::bieg_buf_evt_t buf2_en;
  bieg_pkg::bieg_buf_evt_t buf1_en;
  bieg_pkg::bieg_buf_evt_t buf3_pend;
  bieg_pkg::bieg_buf_evt_t buf2_pend;
  bieg_pkg::bieg_buf_evt_t buf1_pend;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // gather the register port into one request
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire hit_enable = (req.addr == `BIEG_OFS_IRQ_ENABLE);
  wire hit_status = (req.addr == `BIEG_OFS_EVENT_STATUS);
  wire wr_enable  = req.wr & hit_enable;
  wire rd_status  = req.rd & hit_status;

  // ----------------------------------------------------------------
  // event collection
  // ----------------------------------------------------------------

  // new events this cycle, laid out as in the status register
  wire [31:0] evt_word = {bieg_evt_byte(buf3_evt),
                          bieg_evt_byte(buf2_evt),
                          bieg_evt_byte(buf1_evt),
                          8'h00};
  wire [31:0] evt_set  = evt_word & `BIEG_IMPL_MASK;

  // ----------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------

  // only implemented bits take the write, reserved bits stay zero
  assign buffer_irq_enable_reg_d = wr_enable ? (req.wdata & `BIEG_IMPL_MASK)
                                             : buffer_irq_enable_reg_q;

  // enable register storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      buffer_irq_enable_reg_q <= `BIEG_ENABLE_RESET;
    end else begin
      buffer_irq_enable_reg_q <= buffer_irq_enable_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // enable fields
  // ----------------------------------------------------------------

  // buffer 3 enables, top byte
  wire buf3_cell_confirm_en      = buffer_irq_enable_reg_q[`BIEG_BUF3_LSB + `BIEG_FLD_CELL_CONFIRM];
  wire buf3_timestamp_release_en = buffer_irq_enable_reg_q[`BIEG_BUF3_LSB + `BIEG_FLD_TS_RELEASE];
  wire buf3_timestamp_expired_en = buffer_irq_enable_reg_q[`BIEG_BUF3_LSB + `BIEG_FLD_TS_EXPIRED];
  wire buf3_watermark_one_en     = buffer_irq_enable_reg_q[`BIEG_BUF3_LSB + `BIEG_FLD_WM_ONE];
  wire buf3_watermark_zero_en    = buffer_irq_enable_reg_q[`BIEG_BUF3_LSB + `BIEG_FLD_WM_ZERO];
  wire buf3_full_en              = buffer_irq_enable_reg_q[`BIEG_BUF3_LSB + `BIEG_FLD_FULL];
  wire buf3_empty_en             = buffer_irq_enable_reg_q[`BIEG_BUF3_LSB + `BIEG_FLD_EMPTY];

  // buffer 2 enables, second byte
  wire buf2_cell_confirm_en      = buffer_irq_enable_reg_q[`BIEG_BUF2_LSB + `BIEG_FLD_CELL_CONFIRM];
  wire buf2_timestamp_release_en = buffer_irq_enable_reg_q[`BIEG_BUF2_LSB + `BIEG_FLD_TS_RELEASE];
  wire buf2_timestamp_expired_en = buffer_irq_enable_reg_q[`BIEG_BUF2_LSB + `BIEG_FLD_TS_EXPIRED];
  wire buf2_watermark_one_en     = buffer_irq_enable_reg_q[`BIEG_BUF2_LSB + `BIEG_FLD_WM_ONE];
  wire buf2_watermark_zero_en    = buffer_irq_enable_reg_q[`BIEG_BUF2_LSB + `BIEG_FLD_WM_ZERO];
  wire buf2_full_en              = buffer_irq_enable_reg_q[`BIEG_BUF2_LSB + `BIEG_FLD_FULL];
  wire buf2_empty_en             = buffer_irq_enable_reg_q[`BIEG_BUF2_LSB + `BIEG_FLD_EMPTY];

  // buffer 1 enables, third byte; its empty enable lies outside this block
  wire buf1_cell_confirm_en      = buffer_irq_enable_reg_q[`BIEG_BUF1_LSB + `BIEG_FLD_CELL_CONFIRM];
  wire buf1_timestamp_release_en = buffer_irq_enable_reg_q[`BIEG_BUF1_LSB + `BIEG_FLD_TS_RELEASE];
  wire buf1_timestamp_expired_en = buffer_irq_enable_reg_q[`BIEG_BUF1_LSB + `BIEG_FLD_TS_EXPIRED];
  wire buf1_watermark_one_en     = buffer_irq_enable_reg_q[`BIEG_BUF1_LSB + `BIEG_FLD_WM_ONE];
  wire buf1_watermark_zero_en    = buffer_irq_enable_reg_q[`BIEG_BUF1_LSB + `BIEG_FLD_WM_ZERO];
  wire buf1_full_en              = buffer_irq_enable_reg_q[`BIEG_BUF1_LSB + `BIEG_FLD_FULL];

  // enables of each buffer gathered in the same field order as its events
  assign buf3_en = '{cell_confirm: buf3_cell_confirm_en,
                     ts_release:   buf3_timestamp_release_en,
                     ts_expired:   buf3_timestamp_expired_en,
                     wm_one:       buf3_watermark_one_en,
                     wm_zero:      buf3_watermark_zero_en,
                     full:         buf3_full_en,
                     empty:        buf3_empty_en};
  assign buf2_en = '{cell_confirm: buf2_cell_confirm_en,
                     ts_release:   buf2_timestamp_release_en,
                     ts_expired:   buf2_timestamp_expired_en,
                     wm_one:       buf2_watermark_one_en,
                     wm_zero:      buf2_watermark_zero_en,
                     full:         buf2_full_en,
                     empty:        buf2_empty_en};
  assign buf1_en = '{cell_confirm: buf1_cell_confirm_en,
                     ts_release:   buf1_timestamp_release_en,
                     ts_expired:   buf1_timestamp_expired_en,
                     wm_one:       buf1_watermark_one_en,
                     wm_zero:      buf1_watermark_zero_en,
                     full:         buf1_full_en,
                     empty:        1'b0};

  // ----------------------------------------------------------------
  // event status register
  // ----------------------------------------------------------------

  // a read clears the bits it returned; an event in the same cycle wins
  wire [31:0] status_clr = rd_status ? buffer_event_status_reg_q : 32'h0000_0000;
  assign buffer_event_status_reg_d = (buffer_event_status_reg_q & ~status_clr) | evt_set;

  // event status storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      buffer_event_status_reg_q <= `BIEG_STATUS_RESET;
    end else begin
      buffer_event_status_reg_q <= buffer_event_status_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // summary interrupt flags
  // ----------------------------------------------------------------

  // pending events of each buffer, in the same field order as the enables
  assign buf3_pend = bieg_byte_evt(buffer_event_status_reg_q[`BIEG_BUF3_LSB +: 8]);
  assign buf2_pend = bieg_byte_evt(buffer_event_status_reg_q[`BIEG_BUF2_LSB +: 8]);
  assign buf1_pend = bieg_byte_evt(buffer_event_status_reg_q[`BIEG_BUF1_LSB +: 8]);

  // buffers 3 and 2 drive flag one, buffer 1 drives flag zero; a cleared enable masks its event
  wire irq_one_d  = bieg_buf_any(buf3_pend, buf3_en) | bieg_buf_any(buf2_pend, buf2_en);
  wire irq_zero_d = bieg_buf_any(buf1_pend, buf1_en);

  // flags re-evaluated every cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_one_q  <= 1'b0;
      irq_zero_q <= 1'b0;
    end else begin
      irq_one_q  <= irq_one_d;
      irq_zero_q <= irq_zero_d;
    end
  end

  assign summary_buffer_irq_one  = irq_one_q;
  assign summary_buffer_irq_zero = irq_zero_q;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------

  // read mux; unmapped addresses and idle cycles return zero
  assign reg_rdata_d = !req.rd    ? 32'h0000_0000 :
                       hit_enable ? (buffer_irq_enable_reg_q & `BIEG_IMPL_MASK) :
                       hit_status ? (buffer_event_status_reg_q & `BIEG_IMPL_MASK) :
                                    32'h0000_0000;

  // read data stands one cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule : bieg_top

`default_nettype wire

// ==== common/bieg_defines.svh ====
// register offsets, field positions, masks and reset values of the buffer interrupt enable block
`ifndef BIEG_DEFINES_SVH
`define BIEG_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define BIEG_ADDR_W            12
`define BIEG_OFS_EVENT_STATUS  12'h14c
`define BIEG_OFS_IRQ_ENABLE    12'h150

// ----------------------------------------------------------------
// byte lanes of each buffer inside both registers
// ----------------------------------------------------------------
`define BIEG_BUF3_LSB          24
`define BIEG_BUF2_LSB          16
`define BIEG_BUF1_LSB          8

// ----------------------------------------------------------------
// field positions inside one buffer byte
// ----------------------------------------------------------------
`define BIEG_FLD_CELL_CONFIRM  7
`define BIEG_FLD_TS_RELEASE    6
`define BIEG_FLD_TS_EXPIRED    5
`define BIEG_FLD_WM_ONE        4
`define BIEG_FLD_WM_ZERO       3
`define BIEG_FLD_RSVD          2
`define BIEG_FLD_FULL          1
`define BIEG_FLD_EMPTY         0

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define BIEG_IMPL_MASK         32'hfbfbfa00
`define BIEG_IRQ_ONE_MASK      32'hfbfb0000
`define BIEG_IRQ_ZERO_MASK     32'h0000fa00
`define BIEG_ENABLE_RESET      32'h00010000
`define BIEG_STATUS_RESET      32'h00010000

`endif

// ==== common/bieg_pkg.sv ====
// types shared by the buffer interrupt enable block
`default_nettype none

package bieg_pkg;

  // ----------------------------------------------------------------
  // event strobes of one data buffer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cell_confirm;
    logic ts_release;
    logic ts_expired;
    logic wm_one;
    logic wm_zero;
    logic full;
    logic empty;
  } bieg_buf_evt_t;

  // ----------------------------------------------------------------
  // register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bieg_reg_req_t;

endpackage : bieg_pkg

`default_nettype wire

// ==== verification/bieg_top_sva.sv ====
// port assertions of the buffer interrupt enable block
`default_nettype none
module bieg_chk (
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    srst,
  // register port
  input wire logic [11:0]             reg_addr,
  input wire logic [31:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [31:0]             reg_rdata,
  // events and summary flags
  input wire bieg_pkg::bieg_buf_evt_t buf3_evt,
  input wire bieg_pkg::bieg_buf_evt_t buf2_evt,
  input wire bieg_pkg::bieg_buf_evt_t buf1_evt,
  input wire logic                    summary_buffer_irq_one,
  input wire logic                    summary_buffer_irq_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [31:0] en_q;
  // events placed on their register bit positions, raw and enabled
  wire logic [31:0] ev_all = {buf3_evt[6:2], 1'b0, buf3_evt[1:0], buf2_evt[6:2], 1'b0, buf2_evt[1:0],
                              buf1_evt[6:2], 1'b0, buf1_evt[1:0], 8'h00};
  wire logic [31:0] ev_on  = ev_all & en_q;
  // shadow of the enable register, only implemented bits are kept
  always_ff @(posedge core_clk) begin
    if (srst) en_q <= 32'h00010000;
    else if (reg_wr && reg_addr == 12'h150) en_q <= reg_wdata & 32'hfbfbfa00;
  end
  property p_rsvd; (reg_rdata & 32'h040405ff) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read bit set");
  property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_rd_en; reg_rd && reg_addr == 12'h150 |=> reg_rdata == $past(en_q); endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable read back wrong");
  property p_unmap; reg_rd && reg_addr != 12'h150 && reg_addr != 12'h14c |=> reg_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_on_one; |ev_on[31:16] && !reg_wr |-> ##2 summary_buffer_irq_one; endproperty
  a_on_one: assert property (p_on_one) else $error("flag one missed");
  property p_on_zero; |ev_on[15:9] && !reg_wr |-> ##2 summary_buffer_irq_zero; endproperty
  a_on_zero: assert property (p_on_zero) else $error("flag zero missed");
  property p_rise_one; $rose(summary_buffer_irq_one) |-> $past(|(en_q & 32'hfbfb0000)); endproperty
  a_rise_one: assert property (p_rise_one) else $error("flag one without enable");
  property p_rise_zero; $rose(summary_buffer_irq_zero) |-> $past(|(en_q & 32'h0000fa00)); endproperty
  a_rise_zero: assert property (p_rise_zero) else $error("flag zero without enable");
  property p_clr; reg_rd && reg_addr == 12'h14c && ev_all == 32'h0
    |-> ##2 !summary_buffer_irq_one && !summary_buffer_irq_zero; endproperty
  a_clr: assert property (p_clr) else $error("flags stay after status read");
endmodule : bieg_chk

bind bieg_top bieg_chk u_chk (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .buf3_evt, .buf2_evt, .buf1_evt, .summary_buffer_irq_one, .summary_buffer_irq_zero);
`default_nettype wire

// ==== verification/bieg_top_bench.sv ====
// self-checking bench of the buffer interrupt enable block
`default_nettype none
module bieg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    core_clk, srst, reg_wr, reg_rd, irq1, irq0;
  logic [11:0]             reg_addr;
  logic [31:0]             reg_wdata, reg_rdata;
  bieg_pkg::bieg_buf_evt_t buf3_evt, buf2_evt, buf1_evt;
  int                      fail_count, checks_done;
  bieg_top DUT (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .buf3_evt,
    .buf2_evt, .buf1_evt, .summary_buffer_irq_one(irq1), .summary_buffer_irq_zero(irq0));
  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask : rd
  // one-cycle event strobe taken from register bit positions, then let the flag settle
  task automatic ev(input logic [31:0] v);
    @(posedge core_clk);
    buf3_evt <= {v[31:27], v[25:24]};
    buf2_evt <= {v[23:19], v[17:16]};
    buf1_evt <= {v[15:11], v[9:8]};
    @(posedge core_clk);
    {buf3_evt, buf2_evt, buf1_evt} <= 21'h0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : ev
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // watchdog against a hang
  initial begin
    #20000;
    fail_count++;
    stop_test;
  end
  // main sequence
  initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 46'h0};
    {buf3_evt, buf2_evt, buf1_evt} = 21'h0;
    {fail_count, checks_done} = 0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rd(12'h150, 32'h00010000, "enable reset");
    chk("flags", 32'h2, {30'h0, irq1, irq0});
    rd(12'h14c, 32'h00010000, "status reset");
    wr(12'h150, 32'hffffffff);
    rd(12'h150, 32'hfbfbfa00, "enable ones");
    wr(12'h154, 32'h0);
    rd(12'h150, 32'hfbfbfa00, "enable kept");
    rd(12'h154, 32'h0, "unmapped");
    for (int b = 9; b < 32; b++) begin
      if (b % 8 == 2) continue;
      wr(12'h150, ~(32'h1 << b));
      ev(32'h1 << b);
      chk("masked", 32'h0, {30'h0, irq1, irq0});
      rd(12'h14c, 32'h1 << b, "status");
      rd(12'h14c, 32'h0, "status clr");
      wr(12'h150, 32'h1 << b);
      rd(12'h150, 32'h1 << b, "enable bit");
      ev(32'h1 << b);
      chk("flags", {30'h0, b > 15, b < 16}, {30'h0, irq1, irq0});
      rd(12'h14c, 32'h1 << b, "status set");
    end
    // leave a disabled pending event behind, then reset in mid-run
    ev(32'h00100000);
    chk("masked pending", 32'h0, {30'h0, irq1, irq0});
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    rd(12'h150, 32'h00010000, "re-reset");
    chk("flags re-reset", 32'h2, {30'h0, irq1, irq0});
    rd(12'h14c, 32'h00010000, "status re-reset");
    stop_test;
  end
endmodule : bieg_top_bench
`default_nettype wire
